// ---- hdl/cmfc_top.sv ----
/*
  Charger mode selection, fault supervision and status pin logic.
  Analog comparators arrive as synchronous levels; APB master outside.
*/
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps

module cmfc_top
  import cmfc_pkg::*;
#(
  parameter int RETRY_CYC = RETRY_CYC_DEF,
  parameter int PROBE_CYC = PROBE_CYC_DEF,
  parameter int WINDOW_CYC = PRESENCE_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        modeSelectPin,
  input  wire logic        supplyPor,
  input  wire logic        autoVariant,
  input  wire logic        weakBattery,
  input  wire logic        thermalTrip,
  input  wire logic        sleepCond,
  input  wire logic        poorSource,
  input  wire logic        inputOv,
  input  wire logic        batteryOv,
  input  wire logic        aboveRecharge,
  input  wire logic        termCurrent,
  input  wire logic        deepDischarge,
  input  wire logic        aboveUvlo,
  input  wire logic        safetyTimerFault,
  input  wire logic        boostFault,
  output logic             statusOut,
  output logic             statusOe,
  output logic             converterOn,
  output logic             linearTrickle,
  output logic             blockSwitchOn,
  output logic             probeCurrentOn,
  output logic             limit500,
  output logic             limitEnable,
  output logic             timersFrozen,
  output logic [1:0]       opMode
);

  cmfc_chg_t  chg;
  cmfc_mode_t mode;
  logic [6:0] ctrl;
  logic       enStat;
  logic       hostMode;
  logic       pinLimit;
  logic [7:0] faultBits;
  logic       faultPrev;
  logic [31:0] tmr;
  logic [31:0] winCnt;
  logic       winRun;
  logic       winDone;
  logic [15:0] pulseCnt;
  logic       readFault;

  wire apbAcc = psel && penable;
  wire apbWr = apbAcc && pwrite;
  wire chargeFault = thermalTrip || sleepCond || inputOv || batteryOv ||
                     poorSource || !aboveUvlo || safetyTimerFault;
  // fault set follows the selected mode, not the current one, so a boost
  // fault keeps configure mode instead of bouncing back to boost
  wire anyFault = ctrl[B_BOOST] ? (boostFault || safetyTimerFault ||
                  thermalTrip) : chargeFault;
  wire absentNow = (chg == CMFC_PROBE) && (tmr == 32'd0) && !aboveRecharge;
  wire windowAbsent = (chg == CMFC_CHARGE) && winRun && aboveRecharge;
  wire chargeAllowed = (mode == CMFC_MODE_CHARGE) && !ctrl[B_CHG_DIS];

  function automatic logic [31:0] rd_decode(input logic [7:0] a);
    case (a)
      ADDR_STAT_CTRL: rd_decode = {31'h0, enStat};
      ADDR_CTRL:      rd_decode = {25'h0, ctrl};
      ADDR_FAULT:     rd_decode = {24'h0, faultBits};
      ADDR_STATE:     rd_decode = {26'h0, hostMode, winRun, chg, 1'b0} | {30'h0, opMode};
      default:        rd_decode = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_STAT_CTRL) || (a == ADDR_CTRL) || (a == ADDR_FAULT) ||
             (a == ADDR_STATE);
  endfunction

  // single wait-free access: answer in the access cycle
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata <= (psel && !penable && !pwrite) ? rd_decode(paddr) : 32'h0;
    end

  assign readFault = apbAcc && pready && !pwrite && (paddr == ADDR_FAULT);

  // control bits, parameter reset and defaults on absence
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ctrl <= CTRL_RESET;
      enStat <= EN_STAT_RESET;
    end
    else if (ctrl[B_PRESET] || absentNow)
    begin
      ctrl <= CTRL_RESET;
      enStat <= EN_STAT_RESET;
    end
    else if (apbWr && pready)
    begin
      if (paddr == ADDR_CTRL)
        ctrl <= pwdata[6:0];
      if (paddr == ADDR_STAT_CTRL)
        enStat <= pwdata[B_EN_STAT];
    end

  // any bus write moves to host (32-second) mode
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      hostMode <= 1'b0;
    else if (supplyPor || safetyTimerFault)
      hostMode <= 1'b0;
    else if (apbWr && pready)
      hostMode <= 1'b1;

  // power-up cap source caught on supply power-on
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      pinLimit <= 1'b0;
    else if (supplyPor)
      pinLimit <= autoVariant && weakBattery;
    else if (hostMode)
      pinLimit <= 1'b0;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      limit500 <= 1'b0;
      limitEnable <= 1'b1;
    end
    else
    begin
      limit500 <= pinLimit ? modeSelectPin : ctrl[B_LIM_500];
      limitEnable <= !ctrl[B_LIM_DIS];
    end

  // operating mode table
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      mode <= CMFC_MODE_HIZ;
    else if (ctrl[B_HIZ] || windowAbsent)
      mode <= CMFC_MODE_HIZ;
    else if (ctrl[B_BOOST])
      mode <= anyFault ? CMFC_MODE_CONFIG : CMFC_MODE_BOOST;
    else if (!chargeFault)
      mode <= CMFC_MODE_CHARGE;
    else
      mode <= aboveUvlo ? CMFC_MODE_CONFIG : CMFC_MODE_HIZ;

  // charge sequencer
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      chg <= CMFC_IDLE;
      tmr <= 32'd0;
    end
    else if (thermalTrip)
      chg <= chg;
    else
      case (chg)
        CMFC_IDLE:
          if (chargeAllowed)
            chg <= CMFC_TRICKLE;
        CMFC_TRICKLE:
          if (!chargeAllowed)
            chg <= CMFC_IDLE;
          else if (!deepDischarge)
            chg <= CMFC_CHARGE;
        CMFC_CHARGE:
          if (poorSource || windowAbsent)
          begin
            chg <= CMFC_RETRY;
            tmr <= RETRY_CYC;
          end
          else if (!chargeAllowed)
            chg <= CMFC_IDLE;
          else if (deepDischarge)
            chg <= CMFC_TRICKLE;
          else if (hostMode && aboveRecharge && termCurrent)
          begin
            chg <= CMFC_PROBE;
            tmr <= PROBE_CYC;
          end
        CMFC_PROBE:
          if (tmr != 32'd0)
            tmr <= tmr - 32'd1;
          else if (aboveRecharge)
            chg <= CMFC_DONE;
          else
          begin
            chg <= CMFC_RETRY;
            tmr <= RETRY_CYC;
          end
        CMFC_DONE:
          if (!aboveRecharge || !chargeAllowed)
            chg <= CMFC_IDLE;
        CMFC_RETRY:
          if (tmr != 32'd0)
            tmr <= tmr - 32'd1;
          else
            chg <= CMFC_IDLE;
        default:
          chg <= CMFC_IDLE;
      endcase

  // power-up presence window from trickle exit
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      winRun <= 1'b0;
      winDone <= 1'b0;
      winCnt <= 32'd0;
    end
    else if (supplyPor)
    begin
      winRun <= 1'b0;
      winDone <= 1'b0;
      winCnt <= 32'd0;
    end
    else if (thermalTrip)
      winCnt <= winCnt;
    else if (!winRun && !winDone && autoVariant && !hostMode &&
             chg == CMFC_TRICKLE && !deepDischarge && chargeAllowed)
    begin
      winRun <= 1'b1;
      winCnt <= WINDOW_CYC;
    end
    else if (winRun)
    begin
      if (winCnt == 32'd1 || aboveRecharge)
      begin
        winRun <= 1'b0;
        winDone <= 1'b1;
      end
      winCnt <= winCnt - 32'd1;
    end

  // sticky fault bits, new ones only after a read or while all bits are clear
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      faultBits <= 8'h0;
    else if (supplyPor)
      faultBits <= 8'h0;
    else if (faultBits == 8'h0 || readFault)
      faultBits <= {boostFault, safetyTimerFault, !aboveUvlo, poorSource,
                    batteryOv, inputOv, sleepCond, thermalTrip};

  // fault pulse on status pin, restarted by a new fault
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      faultPrev <= 1'b0;
      pulseCnt <= 16'h0;
    end
    else
    begin
      faultPrev <= anyFault || windowAbsent || absentNow;
      if ((anyFault || windowAbsent || absentNow) && !faultPrev)
        pulseCnt <= 16'(FAULT_PULSE_CYC);
      else if (pulseCnt != 16'h0)
        pulseCnt <= pulseCnt - 16'h1;
    end

  // outputs
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      statusOut <= 1'b0;
      statusOe <= 1'b0;
      converterOn <= 1'b0;
      linearTrickle <= 1'b0;
      blockSwitchOn <= 1'b0;
      probeCurrentOn <= 1'b0;
      timersFrozen <= 1'b0;
      opMode <= 2'h0;
    end
    else
    begin
      statusOut <= 1'b0;
      statusOe <= (pulseCnt != 16'h0) || (!anyFault && enStat &&
                  (chg == CMFC_CHARGE || chg == CMFC_TRICKLE));
      converterOn <= !thermalTrip && !sleepCond && !inputOv && !batteryOv &&
                     ((chg == CMFC_CHARGE && mode == CMFC_MODE_CHARGE) ||
                      mode == CMFC_MODE_BOOST);
      linearTrickle <= !thermalTrip && chg == CMFC_TRICKLE;
      blockSwitchOn <= !sleepCond && mode != CMFC_MODE_HIZ;
      probeCurrentOn <= chg == CMFC_PROBE;
      timersFrozen <= thermalTrip;
      opMode <= mode;
    end

  a_probe_entry: assert property (@(posedge clk) disable iff (!rst_b)
    chg == CMFC_CHARGE && !thermalTrip && !poorSource && !windowAbsent &&
    chargeAllowed && !deepDischarge && hostMode && aboveRecharge && termCurrent
    |=> chg == CMFC_PROBE) else $error("probe not entered");
  a_probe_current: assert property (@(posedge clk) disable iff (!rst_b)
    chg == CMFC_PROBE |=> probeCurrentOn) else $error("no probe current");
  a_probe_done: assert property (@(posedge clk) disable iff (!rst_b)
    chg == CMFC_PROBE && tmr == 0 && aboveRecharge && !thermalTrip
    |=> chg == CMFC_DONE) else $error("done missed");
  a_absent_retry: assert property (@(posedge clk) disable iff (!rst_b)
    absentNow && !thermalTrip |=> chg == CMFC_RETRY && ctrl == CTRL_RESET)
    else $error("absent not handled");
  a_thermal_hold: assert property (@(posedge clk) disable iff (!rst_b)
    thermalTrip |=> $stable(chg) && !converterOn) else $error("thermal hold");
  a_hiz_select: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[B_HIZ] |=> ##1 opMode == CMFC_MODE_HIZ) else $error("hiz not taken");
  a_preset_clear: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[B_PRESET] |=> !ctrl[B_PRESET] && ctrl == CTRL_RESET)
    else $error("reset bit stuck");
  a_fault_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    anyFault && !faultPrev |=> ##1 statusOe [*8]) else $error("no fault pulse");
  a_lim_pin: assert property (@(posedge clk) disable iff (!rst_b)
    pinLimit |=> limit500 == $past(modeSelectPin)) else $error("pin cap wrong");
  c_probe: cover property (@(posedge clk) chg == CMFC_PROBE ##1 chg == CMFC_DONE);
  c_retry: cover property (@(posedge clk) chg == CMFC_RETRY);
  c_boost: cover property (@(posedge clk) opMode == CMFC_MODE_BOOST);
  c_window: cover property (@(posedge clk) windowAbsent);
endmodule

// ---- shared/cmfc_pkg.sv ----
/*
  Shared constants for the charger mode and fault control block.
  Assumes a 20 MHz logic clock and an APB slave with 32-bit data.
*/
package cmfc_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int FAULT_PULSE_NS = 128000;
  localparam int FAULT_PULSE_CYC = FAULT_PULSE_NS / (1000000000 / CLK_HZ);
  localparam int PRESENCE_MS = 32;
  localparam int PRESENCE_CYC = PRESENCE_MS * (CLK_HZ / 1000);
  localparam int RETRY_CYC_DEF = 2000;
  localparam int PROBE_CYC_DEF = 1000;

  localparam logic [7:0] ADDR_STAT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;

  localparam int B_EN_STAT = 0;
  localparam int B_CHG_DIS = 0;
  localparam int B_LIM_500 = 1;
  localparam int B_LIM_DIS = 2;
  localparam int B_HIZ = 3;
  localparam int B_BOOST = 4;
  localparam int B_PRESET = 5;
  localparam int B_LIM_REG = 6;

  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic       EN_STAT_RESET = 1'b0;

  typedef enum logic [2:0] {
    CMFC_IDLE, CMFC_TRICKLE, CMFC_CHARGE, CMFC_PROBE, CMFC_DONE, CMFC_RETRY
  } cmfc_chg_t;

  typedef enum logic [1:0] {
    CMFC_MODE_CHARGE, CMFC_MODE_CONFIG, CMFC_MODE_HIZ, CMFC_MODE_BOOST
  } cmfc_mode_t;
endpackage

// ---- tb/charger_mode_fault_control_bench.sv ----
/*
  Bench for the charger mode and fault control block.
  Assumes the host model speaks APB; comparators are driven as levels.
*/
`timescale 1ns/1ps
module charger_mode_fault_control_bench;
  import cmfc_pkg::*;
  logic        clk, rst_b, modeSelectPin, supplyPor, autoVariant, weakBattery;
  logic        aboveUvlo, boostFault, psel, penable, pwrite, pready, pslverr, rerr;
  logic [4:0]  fv;
  logic        aboveRecharge, termCurrent, deepDischarge, linearTrickle, probeCurrentOn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        statusOut, statusOe, converterOn, blockSwitchOn, limit500;
  logic        limitEnable, timersFrozen;
  logic [1:0]  opMode;
  wire         statusPin = statusOe ? statusOut : 1'b1;
  int          lowLen, nPulse, nErrors, totalChecks;

  cmfc_top #(.RETRY_CYC(10), .PROBE_CYC(10), .WINDOW_CYC(50)) u_dut (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .modeSelectPin, .supplyPor, .autoVariant, .weakBattery, .thermalTrip(fv[0]),
    .sleepCond(fv[1]), .poorSource(fv[4]), .inputOv(fv[2]), .batteryOv(fv[3]),
    .aboveRecharge, .termCurrent, .deepDischarge, .aboveUvlo,
    .safetyTimerFault(1'b0), .boostFault, .statusOut, .statusOe, .converterOn,
    .linearTrickle, .blockSwitchOn, .probeCurrentOn, .limit500, .limitEnable,
    .timersFrozen, .opMode);

  cmfc_host u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
                    .prdata, .statusPin, .lowLen, .nPulse);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic endOfTest();
    if (nErrors == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bit ok;
    u_host.xfer(wr, a, d, rdat, rerr, ok);
    if (!ok)
    begin
      nErrors++;
      endOfTest();
    end
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  task automatic scnReset();
    settle();
    chk(limitEnable, 1'b1);
    chk(opMode, CMFC_MODE_HIZ);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat, {25'h0, CTRL_RESET});
    bus(1'b0, ADDR_STAT_CTRL, 32'h0);
    chk(rdat, {31'h0, EN_STAT_RESET});
    bus(1'b0, 8'h10, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
  endtask

  task automatic scnModes();
    aboveUvlo <= 1'b1;
    settle();
    chk(opMode, CMFC_MODE_CHARGE);
    bus(1'b1, ADDR_CTRL, 32'h10);
    settle();
    chk(opMode, CMFC_MODE_BOOST);
    boostFault <= 1'b1;
    settle();
    chk(opMode, CMFC_MODE_CONFIG);
    boostFault <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h18);
    settle();
    chk(opMode, CMFC_MODE_HIZ);
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (2700) @(posedge clk);
  endtask

  task automatic scnFaults();
    int p;
    bus(1'b0, ADDR_FAULT, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      p = nPulse;
      fv <= 5'h1 << i;
      settle();
      chk(converterOn, 1'b0);
      chk(opMode, CMFC_MODE_CONFIG);
      if (i == 0)
        chk(timersFrozen, 1'b1);
      if (i == 1)
        chk(blockSwitchOn, 1'b0);
      bus(1'b0, ADDR_FAULT, 32'h0);
      chk(rdat[i], 1'b1);
      repeat (2700) @(posedge clk);
      chk(nPulse - p, 1);
      chk(lowLen, FAULT_PULSE_CYC);
      fv <= 5'h0;
      settle();
      chk(opMode, CMFC_MODE_CHARGE);
      bus(1'b0, ADDR_FAULT, 32'h0);
    end
  endtask

  task automatic scnLimits();
    bus(1'b1, ADDR_CTRL, 32'h04);
    settle();
    chk(limitEnable, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0a);
    settle();
    chk(limitEnable, 1'b1);
    chk(limit500, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h2a);
    settle();
    chk(limit500, 1'b0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat, {25'h0, CTRL_RESET});
  endtask

  task automatic scnProbe();
    bus(1'b1, ADDR_CTRL, 32'h02);
    deepDischarge <= 1'b1;
    settle();
    chk(linearTrickle, 1'b1);
    deepDischarge <= 1'b0;
    settle();
    chk(linearTrickle, 1'b0);
    aboveRecharge <= 1'b1;
    termCurrent <= 1'b1;
    repeat (4) @(posedge clk);
    chk(probeCurrentOn, 1'b1);
    repeat (16) @(posedge clk);
    chk(probeCurrentOn, 1'b0);
    aboveRecharge <= 1'b0;
    settle();
    aboveRecharge <= 1'b1;
    repeat (2) @(posedge clk);
    aboveRecharge <= 1'b0;
    repeat (4) @(posedge clk);
    chk(probeCurrentOn, 1'b1);
    repeat (16) @(posedge clk);
    termCurrent <= 1'b0;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat, {25'h0, CTRL_RESET});
    chk(limit500, 1'b0);
    repeat (2700) @(posedge clk);
  endtask

  task automatic scnPinCap();
    autoVariant <= 1'b1;
    weakBattery <= 1'b1;
    modeSelectPin <= 1'b1;
    supplyPor <= 1'b1;
    @(posedge clk);
    supplyPor <= 1'b0;
    settle();
    chk(limit500, 1'b1);
    modeSelectPin <= 1'b0;
    settle();
    chk(limit500, 1'b0);
  endtask

  initial
  begin
    {modeSelectPin, supplyPor, autoVariant, weakBattery, aboveUvlo, boostFault} = 6'h0;
    fv = 5'h0;
    {aboveRecharge, termCurrent, deepDischarge} = 3'h0;
    nErrors = 0;
    totalChecks = 0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    scnReset();
    scnModes();
    scnFaults();
    scnLimits();
    scnProbe();
    scnPinCap();
    endOfTest();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    nErrors++;
    endOfTest();
  end
endmodule

// ---- tb/cmfc_host.sv ----
/*
  Host model: APB master tasks and a watcher on the status pin.
  Assumes the status line carries a pull-up and is pulled low by the block.
*/
`timescale 1ns/1ps
module cmfc_host
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  input  wire logic        statusPin,
  output int               lowLen,
  output int               nPulse
);
  int cnt;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cnt = 0;
    lowLen = 0;
    nPulse = 0;
  end

  // called just after a rising edge; request held until pready seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output bit ok);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // length of each low pulse on the status line
  always @(posedge clk)
    if (statusPin === 1'b0)
      cnt <= cnt + 1;
    else if (cnt != 0)
    begin
      lowLen <= cnt;
      nPulse <= nPulse + 1;
      cnt <= 0;
    end
endmodule
